// ===== common/iosel_pkg.sv
// constants, register map and mode codes for the timer pair mode selector
//
// Summary of operation
// R1 - bits 15:12 of ch4-7 select pair 6/7
// R2 - bits 11:8 of ch4-7 select pair 4/5
// R3 - separate selector register for channels 8-11
// R4 - bits 15:12 of ch8-11 select pair 10/11
// R5 - bits 11:8 of ch8-11 select pair 8/9
// R6 - ch12-15 selector, fields at 15:12, 11:8
// R7 - nine binary mode codes, others prohibited
// R8 - software resets timer function before rewriting
// R9 - start/stop mode: odd follows even waveform
// R10 - simultaneous start only in modes 5, 6
// R11 - fields reset to standard; low byte zero
package iosel_pkg;
	// byte addresses of the selector registers
	localparam logic [3:0] ADDR_SEL_CH4_7 = 4'h0;
	localparam logic [3:0] ADDR_SEL_CH8_11 = 4'h4;
	localparam logic [3:0] ADDR_SEL_CH12_15 = 4'h8;
	// field positions inside a selector register
	localparam int HI_FIELD_LSB = 12;
	localparam int LO_FIELD_LSB = 8;
	localparam int FIELD_W = 4;
	// number of channel pairs held here
	localparam int PAIRS = 6;
	// mode codes
	typedef enum logic [3:0] {
		MODE_STANDARD = 4'h0,
		MODE_FULL = 4'h1,
		MODE_SHARED_EXT_TRIG = 4'h2,
		MODE_SHARED_CH_TRIG = 4'h3,
		MODE_START_STOP = 4'h4,
		MODE_SW_START = 4'h5,
		MODE_SW_START_STOP = 4'h6,
		MODE_START = 4'h7,
		MODE_SHARED_TRIG_START_STOP = 4'h8
	} io_mode_t;
	// reset value of every field
	localparam logic [3:0] MODE_RESET = 4'h0;
	localparam logic [3:0] MODE_LAST = 4'h8;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;

	// a code is legal when it names one of the nine modes
	function automatic logic mode_legal(input logic [3:0] code);
		mode_legal = (code <= MODE_LAST);
	endfunction : mode_legal

	// modes in which the odd channel follows the even waveform edges
	function automatic logic mode_start_stop(input logic [3:0] code);
		mode_start_stop = (code == MODE_START_STOP) ||
			(code == MODE_SW_START_STOP) ||
			(code == MODE_SHARED_TRIG_START_STOP);
	endfunction : mode_start_stop
endpackage : iosel_pkg

// ===== verilog/pair_follow.sv
// odd channel run control for one pair in the start/stop modes
module pair_follow
	import iosel_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// mode and even waveform
	input wire logic [3:0] mode_i,
	input wire logic even_wave_i,
	// odd channel controls
	output logic odd_start_o,
	output logic odd_stop_o
);
	// previous waveform level
	logic wave_reg;

	// remember waveform for edge detection
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wave_reg <= 1'b0;
		end else begin
			wave_reg <= even_wave_i;
		end
	end

	// R9 edge driven start and stop
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			odd_start_o <= 1'b0;
			odd_stop_o <= 1'b0;
		end else begin
			odd_start_o <= mode_start_stop(mode_i) && even_wave_i && !wave_reg;
			odd_stop_o <= mode_start_stop(mode_i) && !even_wave_i && wave_reg;
		end
	end
endmodule : pair_follow

// ===== verilog/io_mode_select.sv
// wishbone selector registers for timer channel pairs 4 to 15
module io_mode_select
	import iosel_pkg::*;
(
	// clock and reset
	input wire logic CLK_SYS_I,
	input wire logic RST_I,
	// wishbone slave
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [3:0] ADR_I,
	input wire logic [3:0] SEL_I,
	input wire logic [31:0] DAT_I,
	output logic [31:0] DAT_O,
	output logic ACK_O,
	// timer function state
	input wire logic TIMER_IN_RESET_I,
	// even channel waveforms, one per pair (pair 4/5 at bit 0)
	input wire logic [5:0] EVEN_WAVE_I,
	// per pair mode codes
	output logic [3:0] PAIR_FOUR_FIVE_MODE_O,
	output logic [3:0] PAIR_SIX_SEVEN_MODE_O,
	output logic [3:0] PAIR_EIGHT_NINE_MODE_O,
	output logic [3:0] PAIR_TEN_ELEVEN_MODE_O,
	output logic [3:0] PAIR_TWELVE_THIRTEEN_MODE_O,
	output logic [3:0] PAIR_FOURTEEN_FIFTEEN_MODE_O,
	// odd channel start and stop pulses
	output logic [5:0] ODD_START_O,
	output logic [5:0] ODD_STOP_O,
	// sticky status: prohibited code or rewrite while timer running
	output logic BAD_CODE_O,
	output logic RUNNING_WRITE_O
);
	// mode fields
	logic [3:0] pair_four_five_mode;
	logic [3:0] pair_six_seven_mode;
	logic [3:0] pair_eight_nine_mode;
	logic [3:0] pair_ten_eleven_mode;
	logic [3:0] pair_twelve_thirteen_mode;
	logic [3:0] pair_fourteen_fifteen_mode;
	// bus request this cycle
	logic req;
	// write strobe on lane 1 (bits 15:8)
	logic wr_lane1;
	// address names one of the three selectors
	logic map_hit;
	// gathered modes for the followers
	logic [3:0] mode_arr [PAIRS];

	assign req = CYC_I && STB_I && !ACK_O;
	assign wr_lane1 = req && WE_I && SEL_I[1];
	assign map_hit = (ADR_I == ADDR_SEL_CH4_7) ||
		(ADR_I == ADDR_SEL_CH8_11) || (ADR_I == ADDR_SEL_CH12_15);

	// single cycle ack, dropped the cycle after
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			ACK_O <= 1'b0;
		end else begin
			ACK_O <= req;
		end
	end

	// R1 R2 R11 ch4-7 fields
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			pair_six_seven_mode <= MODE_RESET;
			pair_four_five_mode <= MODE_RESET;
		end else if (wr_lane1 && ADR_I == ADDR_SEL_CH4_7) begin
			pair_six_seven_mode <= DAT_I[HI_FIELD_LSB +: FIELD_W];
			pair_four_five_mode <= DAT_I[LO_FIELD_LSB +: FIELD_W];
		end
	end

	// R3 R4 R5 ch8-11 fields
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			pair_ten_eleven_mode <= MODE_RESET;
			pair_eight_nine_mode <= MODE_RESET;
		end else if (wr_lane1 && ADR_I == ADDR_SEL_CH8_11) begin
			pair_ten_eleven_mode <= DAT_I[HI_FIELD_LSB +: FIELD_W];
			pair_eight_nine_mode <= DAT_I[LO_FIELD_LSB +: FIELD_W];
		end
	end

	// R6 ch12-15 fields
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			pair_fourteen_fifteen_mode <= MODE_RESET;
			pair_twelve_thirteen_mode <= MODE_RESET;
		end else if (wr_lane1 && ADR_I == ADDR_SEL_CH12_15) begin
			pair_fourteen_fifteen_mode <= DAT_I[HI_FIELD_LSB +: FIELD_W];
			pair_twelve_thirteen_mode <= DAT_I[LO_FIELD_LSB +: FIELD_W];
		end
	end

	// read data, low byte and upper half zero
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			DAT_O <= READ_ZERO;
		end else if (req && !WE_I) begin
			DAT_O <= READ_ZERO;
			// R11 low byte reads zero
			if (ADR_I == ADDR_SEL_CH4_7) begin
				DAT_O[HI_FIELD_LSB +: FIELD_W] <= pair_six_seven_mode;
				DAT_O[LO_FIELD_LSB +: FIELD_W] <= pair_four_five_mode;
			end else if (ADR_I == ADDR_SEL_CH8_11) begin
				DAT_O[HI_FIELD_LSB +: FIELD_W] <= pair_ten_eleven_mode;
				DAT_O[LO_FIELD_LSB +: FIELD_W] <= pair_eight_nine_mode;
			end else if (ADR_I == ADDR_SEL_CH12_15) begin
				DAT_O[HI_FIELD_LSB +: FIELD_W] <=
					pair_fourteen_fifteen_mode;
				DAT_O[LO_FIELD_LSB +: FIELD_W] <=
					pair_twelve_thirteen_mode;
			end
		end
	end

	// R7 flag prohibited codes, sticky until reset
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			BAD_CODE_O <= 1'b0;
		end else if (wr_lane1 && map_hit &&
			(!mode_legal(DAT_I[HI_FIELD_LSB +: FIELD_W]) ||
			!mode_legal(DAT_I[LO_FIELD_LSB +: FIELD_W]))) begin
			BAD_CODE_O <= 1'b1;
		end
	end

	// R8 note rewrites while timer not in reset
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			RUNNING_WRITE_O <= 1'b0;
		end else if (wr_lane1 && map_hit &&
			!TIMER_IN_RESET_I) begin
			RUNNING_WRITE_O <= 1'b1;
		end
	end

	// mode outputs are the field flops themselves
	assign PAIR_FOUR_FIVE_MODE_O = pair_four_five_mode;
	assign PAIR_SIX_SEVEN_MODE_O = pair_six_seven_mode;
	assign PAIR_EIGHT_NINE_MODE_O = pair_eight_nine_mode;
	assign PAIR_TEN_ELEVEN_MODE_O = pair_ten_eleven_mode;
	assign PAIR_TWELVE_THIRTEEN_MODE_O = pair_twelve_thirteen_mode;
	assign PAIR_FOURTEEN_FIFTEEN_MODE_O = pair_fourteen_fifteen_mode;

	assign mode_arr[0] = pair_four_five_mode;
	assign mode_arr[1] = pair_six_seven_mode;
	assign mode_arr[2] = pair_eight_nine_mode;
	assign mode_arr[3] = pair_ten_eleven_mode;
	assign mode_arr[4] = pair_twelve_thirteen_mode;
	assign mode_arr[5] = pair_fourteen_fifteen_mode;

	// R9 one follower per pair
	for (genvar g = 0; g < PAIRS; g++) begin : g_pair
		pair_follow u_follow (
			.clk_i(CLK_SYS_I),
			.rst_i(RST_I),
			.mode_i(mode_arr[g]),
			.even_wave_i(EVEN_WAVE_I[g]),
			.odd_start_o(ODD_START_O[g]),
			.odd_stop_o(ODD_STOP_O[g])
		);
	end

	// properties
	property p_ack_one;
		@(posedge CLK_SYS_I) disable iff (RST_I)
		ACK_O |=> !ACK_O;
	endproperty
	a_ack_one: assert property (p_ack_one) // bus
		else $error("ack held more than one cycle");

	property p_ack_req;
		@(posedge CLK_SYS_I) disable iff (RST_I)
		(CYC_I && STB_I && !ACK_O) |=> ACK_O;
	endproperty
	a_ack_req: assert property (p_ack_req) // bus
		else $error("request not acknowledged next cycle");

	property p_hi_47;
		@(posedge CLK_SYS_I) disable iff (RST_I)
		(wr_lane1 && ADR_I == ADDR_SEL_CH4_7) |=>
		PAIR_SIX_SEVEN_MODE_O == $past(DAT_I[15:12]);
	endproperty
	a_hi_47: assert property (p_hi_47) // R1
		else $error("pair 6/7 field wrong");

	property p_lo_47;
		@(posedge CLK_SYS_I) disable iff (RST_I)
		(wr_lane1 && ADR_I == ADDR_SEL_CH4_7) |=>
		PAIR_FOUR_FIVE_MODE_O == $past(DAT_I[11:8]);
	endproperty
	a_lo_47: assert property (p_lo_47) // R2
		else $error("pair 4/5 field wrong");

	property p_keep_811;
		@(posedge CLK_SYS_I) disable iff (RST_I)
		!(wr_lane1 && ADR_I == ADDR_SEL_CH8_11) |=>
		$stable(PAIR_EIGHT_NINE_MODE_O);
	endproperty
	a_keep_811: assert property (p_keep_811) // R3
		else $error("pair 8/9 changed without its write");

	property p_hi_811;
		@(posedge CLK_SYS_I) disable iff (RST_I)
		(wr_lane1 && ADR_I == ADDR_SEL_CH8_11) |=>
		PAIR_TEN_ELEVEN_MODE_O == $past(DAT_I[15:12]);
	endproperty
	a_hi_811: assert property (p_hi_811) // R4
		else $error("pair 10/11 field wrong");

	property p_lo_811;
		@(posedge CLK_SYS_I) disable iff (RST_I)
		(wr_lane1 && ADR_I == ADDR_SEL_CH8_11) |=>
		PAIR_EIGHT_NINE_MODE_O == $past(DAT_I[11:8]);
	endproperty
	a_lo_811: assert property (p_lo_811) // R5
		else $error("pair 8/9 field wrong");

	property p_1215;
		@(posedge CLK_SYS_I) disable iff (RST_I)
		(wr_lane1 && ADR_I == ADDR_SEL_CH12_15) |=>
		{PAIR_FOURTEEN_FIFTEEN_MODE_O, PAIR_TWELVE_THIRTEEN_MODE_O}
		== $past(DAT_I[15:8]);
	endproperty
	a_1215: assert property (p_1215) // R6
		else $error("ch12-15 fields wrong");

	property p_bad;
		@(posedge CLK_SYS_I) disable iff (RST_I)
		(wr_lane1 && map_hit && (DAT_I[15:12] > MODE_LAST ||
		DAT_I[11:8] > MODE_LAST)) |=> BAD_CODE_O;
	endproperty
	a_bad: assert property (p_bad) // R7
		else $error("prohibited code not flagged");

	sequence s_rise;
		!EVEN_WAVE_I[0] ##1 EVEN_WAVE_I[0];
	endsequence
	property p_follow;
		@(posedge CLK_SYS_I) disable iff (RST_I)
		(s_rise ##0 mode_start_stop(PAIR_FOUR_FIVE_MODE_O)) |=>
		ODD_START_O[0];
	endproperty
	a_follow: assert property (p_follow) // R9
		else $error("odd start missing after even rise");

	property p_low_zero;
		@(posedge CLK_SYS_I) disable iff (RST_I)
		ACK_O |-> DAT_O[7:0] == 8'h00;
	endproperty
	a_low_zero: assert property (p_low_zero) // R11
		else $error("low byte not zero");

	sequence s_fall;
		EVEN_WAVE_I[0] ##1 !EVEN_WAVE_I[0];
	endsequence
	property p_stop;
		@(posedge CLK_SYS_I) disable iff (RST_I)
		(s_fall ##0 mode_start_stop(PAIR_FOUR_FIVE_MODE_O)) |=>
		ODD_STOP_O[0];
	endproperty
	a_stop: assert property (p_stop) // R9
		else $error("odd stop missing after even fall");

	property p_no_follow;
		@(posedge CLK_SYS_I) disable iff (RST_I)
		!mode_start_stop(PAIR_TEN_ELEVEN_MODE_O) |=>
		!ODD_START_O[3] && !ODD_STOP_O[3];
	endproperty
	a_no_follow: assert property (p_no_follow) // R9
		else $error("pair 10/11 pulsed outside start/stop modes");

	property p_keep_47;
		@(posedge CLK_SYS_I) disable iff (RST_I)
		!(wr_lane1 && ADR_I == ADDR_SEL_CH4_7) |=>
		$stable(PAIR_SIX_SEVEN_MODE_O) &&
		$stable(PAIR_FOUR_FIVE_MODE_O);
	endproperty
	a_keep_47: assert property (p_keep_47) // R1
		else $error("ch4-7 fields changed without their write");

	property p_keep_1215;
		@(posedge CLK_SYS_I) disable iff (RST_I)
		!(wr_lane1 && ADR_I == ADDR_SEL_CH12_15) |=>
		$stable(PAIR_FOURTEEN_FIFTEEN_MODE_O) &&
		$stable(PAIR_TWELVE_THIRTEEN_MODE_O);
	endproperty
	a_keep_1215: assert property (p_keep_1215) // R6
		else $error("ch12-15 fields changed without their write");

	property p_read_47;
		@(posedge CLK_SYS_I) disable iff (RST_I)
		(req && !WE_I && ADR_I == ADDR_SEL_CH4_7) |=>
		DAT_O[HI_FIELD_LSB +: FIELD_W] == PAIR_SIX_SEVEN_MODE_O &&
		DAT_O[LO_FIELD_LSB +: FIELD_W] == PAIR_FOUR_FIVE_MODE_O;
	endproperty
	a_read_47: assert property (p_read_47) // R2
		else $error("ch4-7 read data wrong");

	property p_unmapped;
		@(posedge CLK_SYS_I) disable iff (RST_I)
		(req && !WE_I && !map_hit) |=> DAT_O == READ_ZERO;
	endproperty
	a_unmapped: assert property (p_unmapped) // R11
		else $error("unmapped read not zero");

	property p_bad_keep;
		@(posedge CLK_SYS_I) disable iff (RST_I)
		BAD_CODE_O |=> BAD_CODE_O;
	endproperty
	a_bad_keep: assert property (p_bad_keep) // R7
		else $error("prohibited code flag lost");

	property p_run;
		@(posedge CLK_SYS_I) disable iff (RST_I)
		(wr_lane1 && map_hit && !TIMER_IN_RESET_I) |=> RUNNING_WRITE_O;
	endproperty
	a_run: assert property (p_run) // R8
		else $error("write while timer running not flagged");
endmodule : io_mode_select

// ===== verification/tb_io_mode_select.sv
// self-checking bench for the timer pair mode selector registers
module tb_io_mode_select import iosel_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	// clock, reset and bus drive
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat_w = 32'h0000_0000;
	logic in_reset = 1'b1;
	logic [5:0] even_wave = 6'h00;
	// observed outputs
	logic [31:0] dat_r;
	logic ack;
	logic [3:0] modes [6];
	logic [5:0] odd_start;
	logic [5:0] odd_stop;
	logic bad_code;
	logic run_write;
	// bookkeeping
	int num_errors = 0;
	int cmp_count = 0;
	logic [31:0] q;
	logic [3:0] hi;
	logic [3:0] lo;
	logic [3:0] addrs [3] = '{ADDR_SEL_CH4_7, ADDR_SEL_CH8_11, ADDR_SEL_CH12_15};

	// free running 100 MHz clock
	initial begin
		forever #5 clk = ~clk;
	end

	io_mode_select DUT (
		.CLK_SYS_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
		.ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack),
		.TIMER_IN_RESET_I(in_reset), .EVEN_WAVE_I(even_wave),
		.PAIR_FOUR_FIVE_MODE_O(modes[0]), .PAIR_SIX_SEVEN_MODE_O(modes[1]),
		.PAIR_EIGHT_NINE_MODE_O(modes[2]), .PAIR_TEN_ELEVEN_MODE_O(modes[3]),
		.PAIR_TWELVE_THIRTEEN_MODE_O(modes[4]),
		.PAIR_FOURTEEN_FIFTEEN_MODE_O(modes[5]),
		.ODD_START_O(odd_start), .ODD_STOP_O(odd_stop),
		.BAD_CODE_O(bad_code), .RUNNING_WRITE_O(run_write)
	);

	// verdict and end of run
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : give_verdict

	// compare seen against expected
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// one classic wishbone cycle, held until ack is sampled
	task automatic wb(input logic wr, input logic [3:0] a,
			input logic [31:0] d, input logic [3:0] s, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		adr <= a;
		sel <= s;
		dat_w <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 16);
		r = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (n >= 16) begin
			num_errors++;
			$display("[ERR] %0t bus answer missing", $time);
			give_verdict();
		end
	endtask : wb

	// move one even waveform and count follower pulses in a short window
	task automatic edge_chk(input int i, input logic lvl, input logic exp);
		int hits;
		hits = 0;
		@(posedge clk);
		even_wave[i] <= lvl;
		repeat (3) begin
			@(posedge clk);
			if ((lvl ? odd_start[i] : odd_stop[i]) === 1'b1) begin
				hits++;
			end
		end
		chk(32'(hits), {31'h0, exp});
	endtask : edge_chk

	// main sequence
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		// reset values of every register and mode output
		for (int r = 0; r < 3; r++) begin
			wb(1'b0, addrs[r], 32'h0000_0000, 4'hF, q);
			chk(q, READ_ZERO);
		end
		for (int i = 0; i < 6; i++) chk(32'(modes[i]), 32'(MODE_RESET));
		$display("test reset values done");
		// every code in both fields of every register
		for (int r = 0; r < 3; r++) begin
			for (int c = 0; c < 9; c++) begin
				hi = 4'(c);
				lo = 4'(8 - c);
				wb(1'b1, addrs[r], {16'hA5A5, hi, lo, 8'hFF}, 4'hF, q);
				wb(1'b0, addrs[r], 32'h0000_0000, 4'hF, q);
				chk(q, {16'h0000, hi, lo, 8'h00});
				chk(32'(modes[2 * r + 1]), 32'(hi));
				chk(32'(modes[2 * r]), 32'(lo));
			end
		end
		chk(32'(bad_code), 32'h0000_0000);
		chk(32'(run_write), 32'h0000_0000);
		$display("test mode codes done");
		// masked byte lane and unmapped address
		wb(1'b1, ADDR_SEL_CH4_7, 32'h0000_3300, 4'hD, q);
		wb(1'b0, ADDR_SEL_CH4_7, 32'h0000_0000, 4'hF, q);
		chk(q, 32'h0000_8000);
		wb(1'b1, 4'hC, 32'h0000_7700, 4'hF, q);
		wb(1'b0, 4'hC, 32'h0000_0000, 4'hF, q);
		chk(q, READ_ZERO);
		chk(32'(modes[4]), 32'h0000_0000);
		wb(1'b1, 4'h6, 32'h0000_F900, 4'hF, q);
		chk(32'(bad_code), 32'h0000_0000);
		$display("test refused accesses done");
		// follower pulses for modes 4, 6, 8 and none for modes 0 and 5
		wb(1'b1, ADDR_SEL_CH4_7, 32'h0000_6400, 4'hF, q);
		wb(1'b1, ADDR_SEL_CH8_11, 32'h0000_0800, 4'hF, q);
		wb(1'b1, ADDR_SEL_CH12_15, 32'h0000_0500, 4'hF, q);
		chk(32'(modes[4]), 32'(MODE_SW_START));
		for (int i = 0; i < 6; i++) begin
			edge_chk(i, 1'b1, i < 3);
			edge_chk(i, 1'b0, i < 3);
		end
		$display("test start stop follower done");
		// prohibited code and write while timer running are flagged
		wb(1'b1, ADDR_SEL_CH12_15, 32'h0000_9000, 4'hF, q);
		wb(1'b0, ADDR_SEL_CH12_15, 32'h0000_0000, 4'hF, q);
		chk(32'(bad_code), 32'h0000_0001);
		chk(32'(run_write), 32'h0000_0000);
		@(posedge clk);
		in_reset <= 1'b0;
		wb(1'b1, ADDR_SEL_CH8_11, 32'h0000_1100, 4'hF, q);
		wb(1'b0, ADDR_SEL_CH8_11, 32'h0000_0000, 4'hF, q);
		chk(32'(run_write), 32'h0000_0001);
		$display("test status flags done");
		// mid-run reset clears flags and fields
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk(32'(bad_code), 32'h0000_0000);
		chk(32'(run_write), 32'h0000_0000);
		chk(32'(modes[5]), 32'(MODE_RESET));
		wb(1'b0, ADDR_SEL_CH8_11, 32'h0000_0000, 4'hF, q);
		chk(q, READ_ZERO);
		$display("test mid-run reset done");
		give_verdict();
	end
endmodule : tb_io_mode_select
